// >>> design/rmr_pkg.sv
/*
  Constants for the radar module host register bank: register indices,
  status bit positions, reset values, packet codes and pacing timing.
  Assumes a 50 MHz system clock.
*/
package rmr_pkg;
  localparam logic [7:0]  PKT_READ         = 8'hF8;
  localparam logic [7:0]  PKT_WRITE        = 8'hF9;

  localparam logic [7:0]  OFF_MAIN_CTRL    = 8'h03;
  localparam logic [7:0]  OFF_STATUS       = 8'h06;
  localparam logic [7:0]  OFF_SERIAL_SPEED = 8'h07;
  localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_PIN      = 8'h09;
  localparam logic [7:0]  OFF_MOD_POWER    = 8'h0A;
  localparam logic [7:0]  OFF_VARIANT_ID   = 8'h10;
  localparam logic [7:0]  OFF_FW_VERSION   = 8'h11;
  localparam logic [7:0]  OFF_SPEED_LIMIT  = 8'h12;
  localparam logic [7:0]  OFF_START_MM     = 8'h20;
  localparam logic [7:0]  OFF_SPAN_MM      = 8'h21;
  localparam logic [7:0]  OFF_PACING       = 8'h22;
  localparam logic [7:0]  OFF_RATE_MHZ     = 8'h23;
  localparam logic [7:0]  OFF_GAIN         = 8'h24;
  localparam logic [7:0]  OFF_SENSOR_POWER = 8'h25;
  localparam logic [7:0]  OFF_OUTBUF_LEN   = 8'hE9;

  localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h04;
  localparam logic [31:0] STATUS_CLEARABLE = 32'hFFFF_FF00;
  localparam logic [31:0] STATUS_LEVELS    = 32'h0000_00FF;
  localparam int          BIT_CREATED      = 0;
  localparam int          BIT_ACTIVATED    = 1;
  localparam int          BIT_DATA_READY   = 8;
  localparam int          BIT_ERROR        = 16;
  localparam int          BIT_BAD_PARAM    = 17;
  localparam int          BIT_BAD_MODE     = 18;
  localparam int          BIT_ACT_FAIL     = 20;
  localparam int          BIT_WRONG_STATE  = 21;

  localparam logic [31:0] RST_SERIAL_SPEED = 32'h0001_C200;
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  localparam logic [31:0] IRQ_PIN_OFF      = 32'h0000_0000;
  localparam logic [31:0] IRQ_PIN_FOLLOW   = 32'h0000_0001;
  localparam logic [31:0] PACE_SENSOR      = 32'h0000_0001;
  localparam logic [31:0] PACE_SOFTWARE    = 32'h0000_0002;
  localparam logic [31:0] GAIN_MAX         = 32'h0000_03E8;
  localparam logic [31:0] POWER_HIBERNATE  = 32'h0000_0004;

  localparam longint      CLK_HZ           = 64'h0000_0000_02FA_F080;
  localparam longint      MHZ_PER_HZ       = 64'h0000_0000_0000_03E8;
  localparam logic [35:0] PACE_WRAP        = 36'(CLK_HZ * MHZ_PER_HZ);

  typedef enum logic [3:0] {
    RMR_ST_TYPE  = 4'b0001,
    RMR_ST_ADDR  = 4'b0010,
    RMR_ST_DATA  = 4'b0100,
    RMR_ST_DRAIN = 4'b1000
  } rmr_state_t;
endpackage : rmr_pkg

// >>> design/rmr_regs.sv
/*
  Host register bank of the radar module: parses register read and write
  packets from the serial byte link, holds configuration, keeps the status
  word and drives the host interrupt pin and the measurement pacing.
  Assumes a serial framer in front that delivers received bytes, marks the
  start of each transaction and requests bytes for host reads.
*/
// What this block does
// [R1] Activation failure sets status bit 20, also usable as mask bit.
// [R2] Writing while writes are forbidden sets status bit 21, write dropped.
// [R3] Serial speed register at 0x07 selects bit rate, starts at 115200.
// [R4] Highest bit rate readable at 0x12; faster settings are refused.
// [R5] Interrupt condition is any status bit set under a set mask bit.
// [R6] Mask bits for created, activated, data ready; zero mask means none.
// [R7] Mask bits for general error, invalid command, invalid mode.
// [R8] Pin mode 0 keeps the host interrupt pin inactive.
// [R9] Pin mode 1 drives the pin exactly with the interrupt condition.
// [R10] Identification register at 0x10 is a fixed code, writes ignored.
// [R11] Version register at 0x11 packs major, minor, patch bytes.
// [R12] Register 0xE9 reports the output buffer fill length.
// [R13] Writable registers store setup; read-only ones show live metadata.
// [R14] Registers 0x20 and 0x21 hold start distance and span in mm.
// [R15] Pacing mode 1: block itself triggers measurements at the rate.
// [R16] Pacing mode 2: requests throttled to the rate; rate zero unlimited.
// [R17] Register 0x23 holds the update rate in millihertz.
// [R18] Gain register 0x24 accepts 0 to 1000 only.
// [R19] Sensor power register 0x25 codes off, sleep, ready, active.
// [R20] Power code 4 stops sensor oscillator; host toggles a pin to move.
// [R21] Host reads by sending 0xF8 and address, then reading four bytes.
// [R22] Host writes by sending 0xF9, address and four bytes together.
// [R23] Clear command 4 to main control clears status bits 31 to 8.
// [R24] Values travel low byte first; interrupt pin follows in one cycle.
module rmr_regs
  import rmr_pkg::*;
#(
  parameter logic [31:0] VARIANT_CODE = 32'h0000_5A01, // Arbitrary value
  parameter logic [7:0]  VER_MAJOR    = 8'h01,
  parameter logic [7:0]  VER_MINOR    = 8'h00,
  parameter logic [7:0]  VER_PATCH    = 8'h00,
  parameter logic [31:0] SPEED_LIMIT  = 32'h0001_C200
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        rx_start,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_req,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        write_allowed,
  input  wire logic [7:0]  status_level,
  input  wire logic [31:0] status_set,
  input  wire logic        activation_failed,
  input  wire logic [31:0] outbuf_length,
  input  wire logic        measure_request,
  output logic             measure_go,
  output logic             host_irq,
  output logic             ctrl_cmd_valid,
  output logic      [7:0]  ctrl_cmd,
  output logic      [31:0] serial_speed,
  output logic      [31:0] module_power_config,
  output logic      [31:0] measure_start_mm,
  output logic      [31:0] measure_span_mm,
  output logic      [31:0] pacing_select,
  output logic      [31:0] refresh_rate_mhz,
  output logic      [31:0] receiver_gain,
  output logic      [31:0] sensor_power_state,
  output logic             sensor_osc_en
);

  rmr_state_t  state;
  logic [7:0]  reg_addr;
  logic [1:0]  byte_idx;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic [31:0] status;
  logic [31:0] irq_enable_bits;
  logic [31:0] irq_pin_behaviour;
  logic [31:0] read_value;
  logic [31:0] next_status;
  logic [31:0] event_set;
  logic        wr_commit;
  logic        wr_legal;
  logic        wr_bad;
  logic        wr_refused;
  logic        clear_cmd;
  logic [35:0] pace_acc;
  logic [35:0] pace_sum;
  logic        pace_tick;
  logic        pace_token;

  // Fourth data byte of a write packet completes the word
  assign wr_commit  = (state == RMR_ST_DATA) && rx_valid && (byte_idx == 2'd3); // [R22]
  assign wr_refused = wr_commit && !write_allowed; // [R2]
  // Value byte 0 sits in wr_word[15:8] when the fourth byte arrives
  assign clear_cmd  = wr_commit && write_allowed && (reg_addr == OFF_MAIN_CTRL)
                      && (wr_word[31:16] == 16'h0000) && (rx_data == 8'h00)
                      && (wr_word[15:8] == CMD_CLEAR_STATUS); // [R23]

  // Range checks on written values; refused writes keep the old value
  always_comb
  begin
    wr_legal = 1'b1;
    wr_bad   = 1'b0;
    if (reg_addr == OFF_SERIAL_SPEED)
      wr_legal = ({rx_data, wr_word[31:8]} <= SPEED_LIMIT); // [R4]
    else if (reg_addr == OFF_GAIN)
      wr_legal = ({rx_data, wr_word[31:8]} <= GAIN_MAX); // [R18]
    else if (reg_addr == OFF_PACING)
      wr_legal = ({rx_data, wr_word[31:8]} == PACE_SENSOR) || ({rx_data, wr_word[31:8]} == PACE_SOFTWARE);
    else if (reg_addr == OFF_SENSOR_POWER)
      wr_legal = ({rx_data, wr_word[31:8]} <= POWER_HIBERNATE); // [R19]
    else if ((reg_addr == OFF_MAIN_CTRL) || (reg_addr == OFF_IRQ_ENABLE) || (reg_addr == OFF_IRQ_PIN)
             || (reg_addr == OFF_MOD_POWER) || (reg_addr == OFF_START_MM) || (reg_addr == OFF_SPAN_MM)
             || (reg_addr == OFF_RATE_MHZ))
    begin
      wr_legal = 1'b1;
    end
    else
    begin
      // Read-only or unmapped: no effect, flagged as a bad command
      wr_legal = 1'b0; // [R10]
    end
    wr_bad = wr_commit && write_allowed && !wr_legal;
  end

  // Packet parser: type byte, address byte, then four value bytes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= RMR_ST_TYPE;
      reg_addr <= 8'h00;
      byte_idx <= 2'd0;
      wr_word  <= RST_ZERO;
    end
    else if (rx_start)
    begin
      state    <= RMR_ST_TYPE;
      byte_idx <= 2'd0;
    end
    else if (rx_valid)
    begin
      case (state)
        RMR_ST_TYPE:
        begin
          if ((rx_data == PKT_READ) || (rx_data == PKT_WRITE)) // [R21]
          begin
            state <= RMR_ST_ADDR;
          end
          else
          begin
            state <= RMR_ST_DRAIN;
          end
          wr_word[0] <= (rx_data == PKT_WRITE);
        end
        RMR_ST_ADDR:
        begin
          reg_addr <= rx_data;
          byte_idx <= 2'd0;
          state    <= wr_word[0] ? RMR_ST_DATA : RMR_ST_DRAIN;
        end
        RMR_ST_DATA:
        begin
          // Low byte first, shifted in from the top
          wr_word  <= {rx_data, wr_word[31:8]}; // [R24]
          byte_idx <= byte_idx + 2'd1;
          if (byte_idx == 2'd3)
          begin
            state <= RMR_ST_DRAIN;
          end
        end
        RMR_ST_DRAIN:
        begin
          state <= RMR_ST_DRAIN;
        end
        default:
        begin
          state <= RMR_ST_TYPE;
        end
      endcase
    end
  end

  // Read decode for the addressed register
  always_comb
  begin
    read_value = RST_ZERO;
    // Unmapped addresses read as zero
    if (reg_addr == OFF_STATUS)
      read_value = status;
    else if (reg_addr == OFF_SERIAL_SPEED)
      read_value = serial_speed;
    else if (reg_addr == OFF_IRQ_ENABLE)
      read_value = irq_enable_bits;
    else if (reg_addr == OFF_IRQ_PIN)
      read_value = irq_pin_behaviour;
    else if (reg_addr == OFF_MOD_POWER)
      read_value = module_power_config;
    else if (reg_addr == OFF_VARIANT_ID)
      read_value = VARIANT_CODE; // [R10]
    else if (reg_addr == OFF_FW_VERSION)
      read_value = {8'h00, VER_MAJOR, VER_MINOR, VER_PATCH}; // [R11]
    else if (reg_addr == OFF_SPEED_LIMIT)
      read_value = SPEED_LIMIT; // [R4]
    else if (reg_addr == OFF_START_MM)
      read_value = measure_start_mm;
    else if (reg_addr == OFF_SPAN_MM)
      read_value = measure_span_mm;
    else if (reg_addr == OFF_PACING)
      read_value = pacing_select;
    else if (reg_addr == OFF_RATE_MHZ)
      read_value = refresh_rate_mhz;
    else if (reg_addr == OFF_GAIN)
      read_value = receiver_gain;
    else if (reg_addr == OFF_SENSOR_POWER)
      read_value = sensor_power_state;
    else if (reg_addr == OFF_OUTBUF_LEN)
      read_value = outbuf_length; // [R12] [R13]
  end

  // Read word is snapshotted at each transaction start (rx_start) so bytes stay coherent
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_word  <= RST_ZERO;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end
    else
    begin
      tx_valid <= tx_req;
      if (rx_start)
      begin
        rd_word <= read_value;
      end
      else if (tx_req)
      begin
        tx_data <= rd_word[7:0]; // [R21] [R24]
        rd_word <= {8'h00, rd_word[31:8]};
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_speed        <= RST_SERIAL_SPEED; // [R3]
      irq_enable_bits     <= RST_ZERO;
      irq_pin_behaviour   <= IRQ_PIN_OFF;
      module_power_config <= RST_ZERO;
      measure_start_mm    <= RST_ZERO;
      measure_span_mm     <= RST_ZERO;
      pacing_select       <= PACE_SENSOR;
      refresh_rate_mhz    <= RST_ZERO;
      receiver_gain       <= RST_ZERO;
      sensor_power_state  <= RST_ZERO;
    end
    else if (wr_commit && write_allowed && wr_legal) // [R13]
    begin
      if (reg_addr == OFF_SERIAL_SPEED)
        serial_speed <= {rx_data, wr_word[31:8]}; // [R3]
      else if (reg_addr == OFF_IRQ_ENABLE)
        irq_enable_bits <= {rx_data, wr_word[31:8]};
      else if (reg_addr == OFF_IRQ_PIN)
        irq_pin_behaviour <= {rx_data, wr_word[31:8]};
      else if (reg_addr == OFF_MOD_POWER)
        module_power_config <= {rx_data, wr_word[31:8]};
      else if (reg_addr == OFF_START_MM)
        measure_start_mm <= {rx_data, wr_word[31:8]}; // [R14]
      else if (reg_addr == OFF_SPAN_MM)
        measure_span_mm <= {rx_data, wr_word[31:8]}; // [R14]
      else if (reg_addr == OFF_PACING)
        pacing_select <= {rx_data, wr_word[31:8]};
      else if (reg_addr == OFF_RATE_MHZ)
        refresh_rate_mhz <= {rx_data, wr_word[31:8]}; // [R17]
      else if (reg_addr == OFF_GAIN)
        receiver_gain <= {rx_data, wr_word[31:8]}; // [R18]
      else if (reg_addr == OFF_SENSOR_POWER)
        sensor_power_state <= {rx_data, wr_word[31:8]}; // [R19]
    end
  end

  // Main control commands, clear included, go out as a pulse; status clearing is done in the status logic
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_cmd_valid <= 1'b0;
      ctrl_cmd       <= 8'h00;
    end
    else
    begin
      ctrl_cmd_valid <= wr_commit && write_allowed && (reg_addr == OFF_MAIN_CTRL);
      if (wr_commit && write_allowed && (reg_addr == OFF_MAIN_CTRL))
      begin
        ctrl_cmd <= wr_word[15:8];
      end
    end
  end

  // Status: low byte mirrors live levels, upper bits sticky; set beats clear
  always_comb
  begin
    event_set                  = status_set & STATUS_CLEARABLE;
    event_set[BIT_ACT_FAIL]    = status_set[BIT_ACT_FAIL] | activation_failed; // [R1]
    event_set[BIT_WRONG_STATE] = status_set[BIT_WRONG_STATE] | wr_refused; // [R2]
    event_set[BIT_BAD_PARAM]   = status_set[BIT_BAD_PARAM] | wr_bad;
    next_status = (clear_cmd ? RST_ZERO : (status & STATUS_CLEARABLE)) | event_set; // [R23]
    next_status = next_status | {24'h00_0000, status_level};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= RST_ZERO;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Host pin registered from next values, so it tracks status in one cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      host_irq <= 1'b0;
    end
    else
    begin
      host_irq <= (irq_pin_behaviour == IRQ_PIN_FOLLOW) && ((next_status & irq_enable_bits) != RST_ZERO); // [R5] [R6] [R7] [R8] [R9] [R24]
    end
  end

  // Rate accumulator in millihertz; one wrap per measurement period
  assign pace_sum  = pace_acc + {4'h0, refresh_rate_mhz};
  assign pace_tick = (pace_sum >= PACE_WRAP);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pace_acc   <= 36'h0_0000_0000;
      pace_token <= 1'b0;
      measure_go <= 1'b0;
    end
    else
    begin
      pace_acc <= pace_tick ? (pace_sum - PACE_WRAP) : pace_sum; // [R17]
      if (pacing_select == PACE_SENSOR)
      begin
        measure_go <= pace_tick; // [R15]
        pace_token <= 1'b0;
      end
      else
      begin
        // Rate limits only: a request passes if a period has elapsed
        measure_go <= measure_request && ((refresh_rate_mhz == RST_ZERO) || pace_token || pace_tick); // [R16]
        if (measure_request && (pace_token || pace_tick))
        begin
          pace_token <= 1'b0;
        end
        else if (pace_tick)
        begin
          pace_token <= 1'b1;
        end
      end
    end
  end

  // Oscillator stopped in hibernate; leaving it relies on host pin toggling
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sensor_osc_en <= 1'b1;
    end
    else
    begin
      sensor_osc_en <= (sensor_power_state != POWER_HIBERNATE); // [R20]
    end
  end

endmodule // rmr_regs

// >>> verification/rmr_regs_assertions.sv
/*
  Port checker for the host register bank, bound into rmr_regs.
  Assumes the single clk domain and arst_n active low.
*/
module rmr_regs_assertions
  import rmr_pkg::*;
#(
  parameter logic [31:0] SPEED_LIMIT = 32'h0001_C200
)
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        rx_valid,
  input wire logic        tx_req,
  input wire logic        tx_valid,
  input wire logic [7:0]  status_level,
  input wire logic [31:0] status_set,
  input wire logic        activation_failed,
  input wire logic        measure_request,
  input wire logic        measure_go,
  input wire logic        ctrl_cmd_valid,
  input wire logic        host_irq,
  input wire logic [31:0] serial_speed,
  input wire logic [31:0] measure_start_mm,
  input wire logic [31:0] pacing_select,
  input wire logic [31:0] refresh_rate_mhz,
  input wire logic [31:0] receiver_gain,
  input wire logic [31:0] sensor_power_state,
  input wire logic        sensor_osc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  tx_answer_a: assert property (tx_valid == $past(tx_req))
    else $error("read byte not answered one cycle after request");
  // Level bits may land one cycle late, so two sample depths
  irq_cause_a: assert property ($rose(host_irq) |-> $past(rx_valid) || $past(rx_valid, 2)
    || $past(activation_failed) || $past(|status_set[31:8])
    || $past(status_level) != $past(status_level, 2) || $past(status_level, 2) != $past(status_level, 3))
    else $error("interrupt pin rose without a cause");
  osc_off_a: assert property ((sensor_power_state == POWER_HIBERNATE)[*2] |-> !sensor_osc_en)
    else $error("oscillator running in hibernate");
  osc_on_a: assert property ((sensor_power_state != POWER_HIBERNATE)[*2] |-> sensor_osc_en)
    else $error("oscillator stopped outside hibernate");
  gain_range_a: assert property (receiver_gain <= GAIN_MAX)
    else $error("gain above limit");
  power_code_a: assert property (sensor_power_state <= POWER_HIBERNATE)
    else $error("sensor power code out of range");
  speed_cap_a: assert property (serial_speed <= SPEED_LIMIT)
    else $error("serial speed above limit");
  cfg_write_a: assert property ($changed(measure_start_mm) |-> $past(rx_valid) || $past(rx_valid, 2))
    else $error("start distance changed without a write");
  cmd_pulse_a: assert property (ctrl_cmd_valid |-> $past(rx_valid) && !$past(ctrl_cmd_valid))
    else $error("control command pulse without a write");
  free_pass_a: assert property (pacing_select == PACE_SOFTWARE && refresh_rate_mhz == 0 && measure_request
    |-> ##[1:2] measure_go)
    else $error("unlimited request not passed");
  go_cause_a: assert property (measure_go |-> $past(measure_request) || $past(measure_request, 2)
    || ($past(pacing_select) == PACE_SENSOR && $past(refresh_rate_mhz) != 0))
    else $error("measurement trigger without cause");

  cover property (measure_go);
  cover property ($rose(host_irq));
  cover property ($fell(sensor_osc_en));
endmodule // rmr_regs_assertions

bind rmr_regs rmr_regs_assertions #(.SPEED_LIMIT(SPEED_LIMIT)) i_chk (
  .clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .tx_req(tx_req), .tx_valid(tx_valid),
  .status_level(status_level), .status_set(status_set), .activation_failed(activation_failed),
  .measure_request(measure_request), .measure_go(measure_go), .ctrl_cmd_valid(ctrl_cmd_valid), .host_irq(host_irq),
  .serial_speed(serial_speed), .measure_start_mm(measure_start_mm), .pacing_select(pacing_select),
  .refresh_rate_mhz(refresh_rate_mhz), .receiver_gain(receiver_gain),
  .sensor_power_state(sensor_power_state), .sensor_osc_en(sensor_osc_en));

// >>> verification/rmr_host_model.sv
/*
  Host side model: sends register read and write packets as bytes.
  Assumes the bench clock; requests change just after rising edges.
*/
module rmr_host_model
  import rmr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  output logic            rx_start,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rx_start, rx_valid, rx_data, tx_req} = '0;

  task automatic put(input logic [7:0] b);
    @(posedge clk);
    rx_start <= 1'b0;
    rx_valid <= 1'b1;
    rx_data  <= b;
  endtask
  // Idle data keeps toggling so a stale byte cannot pass
  task automatic mark(input logic st);
    @(posedge clk);
    rx_start <= st;
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    mark(1'b1);
    put(PKT_WRITE);
    put(a);
    for (int i = 0; i < 4; i++) put(v[8*i+:8]);
    mark(1'b0);
    @(posedge clk);
    @(negedge clk);
  endtask
  // Second start must follow the address byte: it takes the snapshot
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    mark(1'b1);
    put(PKT_READ);
    put(a);
    mark(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      rx_start <= 1'b0;
      tx_req   <= 1'b1;
      @(posedge clk);
      tx_req   <= 1'b0;
      @(negedge clk);
      v[8*i+:8] = tx_data;
    end
  endtask
endmodule // rmr_host_model

// >>> verification/rmr_regs_tb.sv
/*
  Self-checking bench for rmr_regs with the host model on the link.
  Assumes rmr_pkg constants; status sources are driven by the bench.
*/
module rmr_regs_tb
  import rmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VAR_ID = 32'h0000_3C07; // Arbitrary value
  localparam logic [7:0]  VMAJ   = 8'h02;
  localparam logic [7:0]  VMIN   = 8'h03;
  localparam logic [7:0]  VPAT   = 8'h04;
  localparam logic [31:0] LIMIT  = 32'h0003_8400;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rx_start, rx_valid, tx_req, tx_valid, write_allowed, activation_failed;
  logic        measure_request, measure_go, host_irq, ctrl_cmd_valid, sensor_osc_en;
  logic [7:0]  rx_data, tx_data, status_level, ctrl_cmd;
  logic [31:0] status_set, outbuf_length, serial_speed, module_power_config, measure_start_mm;
  logic [31:0] measure_span_mm, pacing_select, refresh_rate_mhz, receiver_gain, sensor_power_state;
  int          bad_count = 0;
  int          checks_done = 0;

  rmr_regs #(.VARIANT_CODE(VAR_ID), .VER_MAJOR(VMAJ), .VER_MINOR(VMIN), .VER_PATCH(VPAT),
    .SPEED_LIMIT(LIMIT)) i_dut (.*);
  rmr_host_model h (.*);

  always #10 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    h.rd(a, v);
    chk(v, e);
  endtask
  task automatic rds(input logic [31:0] m);
    logic [31:0] v;
    h.rd(OFF_STATUS, v);
    chk(v & m, m);
  endtask
  task automatic pulse(input logic [31:0] s, input logic af, input logic [7:0] lv);
    @(posedge clk);
    status_set <= s;
    activation_failed <= af;
    status_level <= lv;
    @(posedge clk);
    status_set <= '0;
    activation_failed <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_ident;
    rdc(OFF_SERIAL_SPEED, RST_SERIAL_SPEED);
    h.wr(OFF_VARIANT_ID, 32'h0000_0000);
    rdc(OFF_VARIANT_ID, VAR_ID);
    rdc(OFF_FW_VERSION, {8'h00, VMAJ, VMIN, VPAT});
    rdc(OFF_SPEED_LIMIT, LIMIT);
    rdc(OFF_OUTBUF_LEN, 32'h0000_0123);
    // Fill length is live, not latched
    @(posedge clk) outbuf_length <= 32'h0000_0456;
    rdc(OFF_OUTBUF_LEN, 32'h0000_0456);
    h.wr(OFF_SERIAL_SPEED, LIMIT + 32'h0000_0001);
    chk(serial_speed, RST_SERIAL_SPEED);
    h.wr(OFF_SERIAL_SPEED, LIMIT);
    chk(serial_speed, LIMIT);
  endtask
  task automatic t_config;
    h.wr(OFF_START_MM, 32'h0000_03E8);
    chk(measure_start_mm, 32'h0000_03E8);
    h.wr(OFF_SPAN_MM, 32'h1234_5678);
    rdc(OFF_SPAN_MM, 32'h1234_5678);
    h.wr(OFF_MOD_POWER, 32'h0000_0001);
    chk(module_power_config, 32'h0000_0001);
    // Earlier refusals left bit 17 set; clear so only the gain write can set it
    h.wr(OFF_MAIN_CTRL, 32'h0000_0004);
    rdc(OFF_STATUS, 32'h0000_0000);
    h.wr(OFF_GAIN, GAIN_MAX);
    h.wr(OFF_GAIN, GAIN_MAX + 32'h0000_0001);
    chk(receiver_gain, GAIN_MAX);
    rds(32'h0002_0000);
  endtask
  task automatic t_state;
    @(posedge clk) write_allowed <= 1'b0;
    h.wr(OFF_START_MM, 32'h0000_0007);
    @(posedge clk) write_allowed <= 1'b1;
    chk(measure_start_mm, 32'h0000_03E8);
    rds(32'h0020_0000);
  endtask
  task automatic t_irq;
    logic [31:0] mb [7];
    mb = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0100, 32'h0001_0000,
           32'h0002_0000, 32'h0004_0000, 32'h0010_0000};
    h.wr(OFF_MAIN_CTRL, 32'h0000_0004);
    chk({24'h00_0000, ctrl_cmd}, 32'h0000_0004);
    h.wr(OFF_IRQ_ENABLE, 32'h0000_0100);
    pulse(32'h0000_0100, 1'b0, 8'h00);
    chk(host_irq, 1'b0);
    h.wr(OFF_IRQ_PIN, IRQ_PIN_FOLLOW);
    chk(host_irq, 1'b1);
    h.wr(OFF_MAIN_CTRL, 32'h0000_0004);
    chk(host_irq, 1'b0);
    h.wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    pulse(32'hFFFF_FF00, 1'b1, 8'h03);
    chk(host_irq, 1'b0);
    pulse('0, 1'b0, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      h.wr(OFF_MAIN_CTRL, 32'h0000_0004);
      h.wr(OFF_IRQ_ENABLE, mb[i]);
      chk(host_irq, 1'b0);
      pulse((i > 1 && i < 6) ? mb[i] : '0, i == 6, mb[i][7:0]);
      chk(host_irq, 1'b1);
      // Level bits survive the clear command
      h.wr(OFF_MAIN_CTRL, 32'h0000_0004);
      chk(host_irq, 32'(i < 2));
      pulse('0, 1'b0, 8'h00);
    end
  endtask
  task automatic t_pace;
    int n;
    h.wr(OFF_RATE_MHZ, 32'h9502_F900);
    rdc(OFF_RATE_MHZ, 32'h9502_F900);
    n = 0;
    repeat (200) @(negedge clk) n += int'(measure_go === 1'b1);
    chk(32'(n), 32'd10);
    h.wr(OFF_PACING, PACE_SOFTWARE);
    // Steady requests: one pass per 20-cycle wrap after the token is spent
    @(posedge clk) measure_request <= 1'b1;
    repeat (20) @(negedge clk);
    n = 0;
    repeat (200) @(negedge clk) n += int'(measure_go === 1'b1);
    @(posedge clk) measure_request <= 1'b0;
    chk(32'(n), 32'd10);
    h.wr(OFF_RATE_MHZ, 32'h0000_0000);
    h.wr(OFF_PACING, 32'h0000_0003);
    chk(pacing_select, PACE_SOFTWARE);
    @(posedge clk) measure_request <= 1'b1;
    @(posedge clk) measure_request <= 1'b0;
    n = 0;
    repeat (3) @(negedge clk) n += int'(measure_go === 1'b1);
    chk(32'(n), 32'd1);
  endtask
  task automatic t_power;
    h.wr(OFF_SENSOR_POWER, POWER_HIBERNATE);
    chk(sensor_osc_en, 1'b0);
    h.wr(OFF_SENSOR_POWER, 32'h0000_0005);
    chk(sensor_power_state, POWER_HIBERNATE);
    for (int c = 3; c >= 0; c--)
    begin
      h.wr(OFF_SENSOR_POWER, 32'(c));
      chk(sensor_power_state, 32'(c));
      chk(sensor_osc_en, 1'b1);
    end
  endtask

  initial
  begin
    {write_allowed, activation_failed, measure_request} = 3'b100;
    status_level = 8'h00;
    status_set = '0;
    outbuf_length = 32'h0000_0123;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_ident();
    t_config();
    t_state();
    t_irq();
    t_pace();
    t_power();
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("Error %0t: run timed out", $time);
    report_and_stop();
  end
endmodule // rmr_regs_tb
